// ---- verilog/tcu_top.sv ----
// Timer control and interrupt block with APB register access
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module tcu_top
  import tcu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  capture_pin,
  input  wire logic        debug_halt,
  input  wire logic [1:0]  pwm_level,
  input  wire logic [1:0]  timeout_evt,
  input  wire logic [1:0]  capture_match_evt,
  input  wire logic        clock_alarm_evt,
  output logic [1:0]       pwm_out,
  output logic [1:0]       count_run,
  output logic [1:0]       capture_edge,
  output logic [1:0]       trigger_out,
  output logic             irq
);

  logic [31:0]      ctrl_reg;
  logic [1:0]       enable_reg;
  logic [1:0]       armed_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] raw_reg;
  logic [IRQ_W-1:0] raw_next;
  logic [1:0]       cap_meta_reg;
  logic [1:0]       cap_sync_reg;
  logic [1:0]       cap_prev_reg;
  logic [1:0]       dbg_sync_reg;
  logic [1:0]       hit;
  logic [1:0]       run;
  logic [1:0]       halted;
  logic             acc_first;
  logic [IRQ_W-1:0] src_evt;
  logic [IRQ_W-1:0] clr_mask;
  logic [IRQ_W-1:0] masked_stat;
  logic [3:0]       status_word;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [31:0]      rd_data;
  tcu_cfg_t         cfg [2];
  tcu_evt_t         evt [2];

  // Exact byte-address match
  function automatic logic sel_addr(input logic [7:0] a, input logic [7:0] ofs);
    sel_addr = (a == ofs);
  endfunction

  // Unused code 2 behaves as rising edge
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    case (sel)
      EDGE_BOTH: edge_hit = now ^ prev;
      EDGE_FALL: edge_hit = !now && prev;
      default:   edge_hit = now && !prev;
    endcase
  endfunction

  // One wait state: effect in the first access cycle, pready in the next
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign acc_first   = psel && penable && !pready;
  assign masked_stat = raw_reg & imask_reg;
  // Status: armed flags above run flags
  assign status_word = {armed_reg, run};

  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:   rd_data = ctrl_reg;
      OFS_CMD:    rd_data = {30'h0000_0000, enable_reg};
      OFS_IMASK:  rd_data = {25'h000_0000, imask_reg};
      // Write-only registers read as zero
      OFS_IMSET:  rd_data = 32'h0000_0000;
      OFS_IMCLR:  rd_data = 32'h0000_0000;
      OFS_ICLR:   rd_data = 32'h0000_0000;
      OFS_RAW:    rd_data = {25'h000_0000, raw_reg};
      OFS_MASKED: rd_data = {25'h000_0000, masked_stat};
      OFS_STATUS: rd_data = {28'h000_0000, status_word};
      default:    addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      // Registered answer: pready rises one cycle into the access phase
      pready  <= acc_first;
      pslverr <= acc_first && !addr_ok;
      // Read data stands only with pready; writes and errors answer zero
      if (rd_en && !pready)
      begin
        prdata <= rd_data;
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration; A and B fields written together cover the both-counter case
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RST;
    end
    else if (wr_en && !pready && sel_addr(paddr, OFS_CTRL))
    begin
      // Reserved bits are kept but drive nothing
      ctrl_reg <= pwdata;
    end
  end

  // Pins from outside pass two flops before use
  // Pin pulses shorter than one clock may be missed
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cap_meta_reg <= 2'b00;
      cap_sync_reg <= 2'b00;
      cap_prev_reg <= 2'b00;
      dbg_sync_reg <= 2'b00;
    end
    else
    begin
      cap_meta_reg <= capture_pin;
      cap_sync_reg <= cap_meta_reg;
      cap_prev_reg <= cap_sync_reg;
      dbg_sync_reg <= {dbg_sync_reg[0], debug_halt};
    end
  end

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_cnt
      assign cfg[i] = tcu_cfg_t'(ctrl_reg[i*CTRL_B_POS +: 6]);
      assign hit[i]    = edge_hit(cfg[i].edge_sel, cap_sync_reg[i], cap_prev_reg[i]);
      assign halted[i] = cfg[i].halt_in_debug && dbg_sync_reg[1];
      assign run[i]    = enable_reg[i] && armed_reg[i] && !halted[i];
      // Capture events only count while the counter runs
      assign evt[i] = '{capture_match: capture_match_evt[i], capture_event: hit[i] && run[i],
                        timeout: timeout_evt[i]};

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          enable_reg[i] <= 1'b0;
          armed_reg[i]  <= 1'b0;
        end
        else
        begin
          // Disable beats enable when both bits are written together
          if (wr_en && !pready && sel_addr(paddr, OFS_CMD) && pwdata[CMD_DIS_A + i])
          begin
            enable_reg[i] <= 1'b0;
            armed_reg[i]  <= 1'b0;
          end
          else if (wr_en && !pready && sel_addr(paddr, OFS_CMD) && pwdata[CMD_EN_A + i])
          begin
            enable_reg[i] <= 1'b1;
            armed_reg[i]  <= !cfg[i].start_on_chain_trigger;
          end
          // A waits on the timeout of B and B on that of A
          else if (enable_reg[i] && !armed_reg[i] && timeout_evt[(i + 1) % 2])
          begin
            armed_reg[i] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          pwm_out[i]      <= 1'b0;
          count_run[i]    <= 1'b0;
          capture_edge[i] <= 1'b0;
          trigger_out[i]  <= 1'b0;
        end
        else
        begin
          // Registered so every port comes from a flop
          pwm_out[i]      <= pwm_level[i] ^ cfg[i].pwm_active_low;
          count_run[i]    <= run[i];
          capture_edge[i] <= hit[i] && run[i];
          trigger_out[i]  <= timeout_evt[i] && cfg[i].trigger_out_enable;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      imask_reg <= IMASK_RST;
    end
    else if (wr_en && !pready)
    begin
      // Full load, or set and clear by bit mask
      if (sel_addr(paddr, OFS_IMASK))
      begin
        imask_reg <= pwdata[IRQ_W-1:0];
      end
      else if (sel_addr(paddr, OFS_IMSET))
      begin
        imask_reg <= imask_reg | pwdata[IRQ_W-1:0];
      end
      else if (sel_addr(paddr, OFS_IMCLR))
      begin
        imask_reg <= imask_reg & ~pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sources gathered in the interrupt bit layout
  always_comb
  begin
    src_evt           = {IRQ_W{1'b0}};
    src_evt[IRQ_A_TO] = evt[0].timeout;
    src_evt[IRQ_A_CM] = evt[0].capture_match;
    src_evt[IRQ_A_CE] = evt[0].capture_event;
    src_evt[IRQ_RTC]  = clock_alarm_evt;
    src_evt[IRQ_B_TO] = evt[1].timeout;
    src_evt[IRQ_B_CM] = evt[1].capture_match;
    src_evt[IRQ_B_CE] = evt[1].capture_event;
  end

  // Bits dropped this cycle by the clear mask or by clear-on-read
  always_comb
  begin
    clr_mask = {IRQ_W{1'b0}};
    if (wr_en && !pready && sel_addr(paddr, OFS_ICLR))
    begin
      clr_mask = pwdata[IRQ_W-1:0];
    end
    if (rd_en && !pready && sel_addr(paddr, OFS_RAW))
    begin
      clr_mask = {IRQ_W{1'b1}};
    end
  end

  // New events win over a clear or clear-on-read in the same cycle
  generate
    for (genvar b = 0; b < IRQ_W; b++)
    begin : g_raw
      assign raw_next[b] = src_evt[b] || (raw_reg[b] && !clr_mask[b]);
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      raw_reg <= {IRQ_W{1'b0}};
      irq     <= 1'b0;
    end
    else
    begin
      // The irq level tracks raw_next; a mask write shows one cycle later
      raw_reg <= raw_next;
      irq     <= |(raw_next & imask_reg);
    end
  end

endmodule

// ---- verilog/tcu_pkg.sv ----
// Package for the timer control and interrupt block: offsets, fields, reset values
package tcu_pkg;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CMD      = 8'h04;
  localparam logic [7:0]  OFS_IMASK    = 8'h08;
  localparam logic [7:0]  OFS_IMSET    = 8'h0C;
  localparam logic [7:0]  OFS_IMCLR    = 8'h10;
  localparam logic [7:0]  OFS_ICLR     = 8'h14;
  localparam logic [7:0]  OFS_RAW      = 8'h18;
  localparam logic [7:0]  OFS_MASKED   = 8'h1C;
  localparam logic [7:0]  OFS_STATUS   = 8'h20;
  // Control word: one 6-bit field per counter, B at bit 8
  localparam int          CTRL_B_POS   = 8;
  localparam int          F_EDGE_POS   = 0;
  localparam int          F_ACTLOW_POS = 2;
  localparam int          F_HALT_POS   = 3;
  localparam int          F_TRIG_POS   = 4;
  localparam int          F_WAIT_POS   = 5;
  // Edge select codes
  localparam logic [1:0]  EDGE_RISE    = 2'h0;
  localparam logic [1:0]  EDGE_FALL    = 2'h1;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  // Command word bits
  localparam int          CMD_EN_A     = 0;
  localparam int          CMD_EN_B     = 1;
  localparam int          CMD_DIS_A    = 2;
  localparam int          CMD_DIS_B    = 3;
  // Interrupt bit layout
  localparam int          IRQ_W        = 7;
  localparam int          IRQ_A_TO     = 0;
  localparam int          IRQ_A_CM     = 1;
  localparam int          IRQ_A_CE     = 2;
  localparam int          IRQ_RTC      = 3;
  localparam int          IRQ_B_TO     = 4;
  localparam int          IRQ_B_CM     = 5;
  localparam int          IRQ_B_CE     = 6;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [6:0]  IMASK_RST    = 7'h00;

  typedef struct packed {
    logic       start_on_chain_trigger;
    logic       trigger_out_enable;
    logic       halt_in_debug;
    logic       pwm_active_low;
    logic [1:0] edge_sel;
  } tcu_cfg_t;

  typedef struct packed {
    logic capture_match;
    logic capture_event;
    logic timeout;
  } tcu_evt_t;
endpackage

// ---- sim/tcu_chk_assertions.sv ----
// Port-level checker for bus timing, outputs and interrupt level
`timescale 1ns/1ps
module tcu_chk
  import tcu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  pwm_level,
  input wire logic [1:0]  timeout_evt,
  input wire logic [1:0]  capture_match_evt,
  input wire logic        clock_alarm_evt,
  input wire logic [1:0]  pwm_out,
  input wire logic [1:0]  capture_edge,
  input wire logic [1:0]  trigger_out,
  input wire logic        irq
);
  logic [15:0] cfg_reg;
  // Shadow of both control fields, taken on the write edge
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      cfg_reg <= 16'h0000;
    else if (psel && penable && pwrite && !pready && paddr == OFS_CTRL)
      cfg_reg <= pwdata[15:0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_map: assert property (pready |-> pslverr == (paddr > OFS_STATUS || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("prdata on error");
  a_pwm_polarity: assert property (pwm_out == $past(pwm_level ^ {cfg_reg[10], cfg_reg[2]}))
    else $error("pwm polarity");
  a_trig_gate: assert property (trigger_out == $past(timeout_evt & {cfg_reg[12], cfg_reg[4]}))
    else $error("trigger gating");
  a_irq_hold: assert property (irq && !psel |=> irq)
    else $error("irq dropped");
  a_irq_cause: assert property ($rose(irq) |-> |capture_edge ||
    $past(|{timeout_evt, capture_match_evt, clock_alarm_evt, capture_edge, psel})) else $error("irq uncaused");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_trig: cover property (|trigger_out);
endmodule

// ---- sim/tcu_top_tb.sv ----
// Directed testbench for the timer control and interrupt block
`timescale 1ns/1ps
module tcu_top_tb;
  import tcu_pkg::*;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, debug_halt = 0, clock_alarm_evt = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [1:0]  capture_pin = 2'h0, pwm_level = 2'h0, timeout_evt = 2'h0, capture_match_evt = 2'h0;
  logic [1:0]  pwm_out, count_run, capture_edge, trigger_out;
  logic        pready, pslverr, irq, e;
  int          fails = 0, comparisons = 0, cyc = 0;
  tcu_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .capture_pin(capture_pin),
    .debug_halt(debug_halt), .pwm_level(pwm_level), .timeout_evt(timeout_evt), .capture_match_evt(capture_match_evt),
    .clock_alarm_evt(clock_alarm_evt), .pwm_out(pwm_out), .count_run(count_run), .capture_edge(capture_edge),
    .trigger_out(trigger_out), .irq(irq));
  always #2 clk_sys = ~clk_sys;
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 5000)
    begin
      fails++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic pz(input logic [1:0] t, input logic [1:0] m, input logic c);
    @(posedge clk_sys);
    timeout_evt <= t;
    capture_match_evt <= m;
    clock_alarm_evt <= c;
    @(posedge clk_sys);
    timeout_evt <= 2'h0;
    capture_match_evt <= 2'h0;
    clock_alarm_evt <= 1'b0;
    #1;
  endtask
  task automatic cap(input logic v, input logic [31:0] x);
    logic [31:0] n;
    n = 32'h0;
    @(posedge clk_sys);
    capture_pin[0] <= v;
    repeat (8)
    begin
      @(posedge clk_sys);
      #1;
      n = n + capture_edge[0];
    end
    chk("capture_edges", x, n);
  endtask
  task automatic t_map;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_reset", CTRL_RST, r);
    apb(1'b0, OFS_IMASK, 32'h0);
    chk("imask_reset", 32'(IMASK_RST), r);
    apb(1'b1, 8'h40, 32'hFFFF);
    chk("unmapped_err", 32'h1, 32'(e));
    apb(1'b1, OFS_CTRL, 32'h1004);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_both", 32'h1004, r);
  endtask
  task automatic t_out;
    @(posedge clk_sys);
    pwm_level <= 2'h3;
    settle;
    chk("pwm_out", 32'h2, 32'(pwm_out));
    pz(2'h3, 2'h0, 1'b0);
    chk("trigger_out", 32'h2, 32'(trigger_out));
  endtask
  task automatic t_irq;
    apb(1'b1, OFS_ICLR, 32'h7F);
    pz(2'h0, 2'h1, 1'b1);
    settle;
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b0, OFS_MASKED, 32'h0);
    chk("masked_none", 32'h0, r);
    apb(1'b1, OFS_IMSET, 32'h8);
    settle;
    chk("irq_on", 32'h1, 32'(irq));
    apb(1'b0, OFS_MASKED, 32'h0);
    chk("masked_alarm", 32'h8, r);
    apb(1'b1, OFS_ICLR, 32'h8);
    settle;
    chk("irq_cleared", 32'h0, 32'(irq));
    apb(1'b0, OFS_RAW, 32'h0);
    chk("raw_sticky", 32'h2, r);
    apb(1'b0, OFS_RAW, 32'h0);
    chk("raw_read_clear", 32'h0, r);
    pz(2'h3, 2'h3, 1'b1);
    apb(1'b0, OFS_RAW, 32'h0);
    chk("raw_sources", 32'h3B, r);
  endtask
  task automatic t_run;
    apb(1'b1, OFS_CMD, 32'h3);
    settle;
    chk("run_both", 32'h3, 32'(count_run));
    apb(1'b1, OFS_CTRL, 32'h8);
    debug_halt <= 1'b1;
    repeat (3) settle;
    chk("halt_a", 32'h2, 32'(count_run));
    @(posedge clk_sys);
    debug_halt <= 1'b0;
    apb(1'b1, OFS_CMD, 32'hF);
    settle;
    chk("stop_both", 32'h0, 32'(count_run));
  endtask
  task automatic t_wait;
    apb(1'b1, OFS_CTRL, 32'h20);
    apb(1'b1, OFS_CMD, 32'h1);
    settle;
    chk("wait_idle", 32'h0, 32'(count_run));
    pz(2'h2, 2'h0, 1'b0);
    settle;
    chk("wait_go", 32'h1, 32'(count_run));
  endtask
  task automatic t_cap;
    apb(1'b1, OFS_CTRL, 32'(EDGE_FALL));
    cap(1'b1, 32'h0);
    cap(1'b0, 32'h1);
    apb(1'b1, OFS_CTRL, 32'(EDGE_BOTH));
    cap(1'b1, 32'h1);
    apb(1'b1, OFS_CTRL, 32'(EDGE_RISE));
    cap(1'b0, 32'h0);
    cap(1'b1, 32'h1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_map;
    t_out;
    t_irq;
    t_run;
    t_wait;
    t_cap;
    wrap_up;
  end
endmodule
bind tcu_top tcu_chk u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_level(pwm_level),
  .timeout_evt(timeout_evt), .capture_match_evt(capture_match_evt), .clock_alarm_evt(clock_alarm_evt),
  .pwm_out(pwm_out), .capture_edge(capture_edge), .trigger_out(trigger_out), .irq(irq));
